// File: pkg/xt_params.svh
// Offsets, field positions, reset values and presets of the trace capture front end
`ifndef XT_PARAMS_SVH
`define XT_PARAMS_SVH

// Register indices on the plain port
`define XT_A_CTRL 4'h0
`define XT_A_THR_LO 4'h1
`define XT_A_THR_HI 4'h2
`define XT_A_EDGE 4'h3
`define XT_A_LBL_WR 4'h4
`define XT_A_LBL_CNT 4'h5
`define XT_A_COMMIT 4'h6
`define XT_A_STATUS 4'h7
`define XT_A_TRACE 4'h8
`define XT_A_LBL_SEL 4'h9

// Field positions
`define XT_CTRL_OWN 0
`define XT_CTRL_MODE 2:1
`define XT_CTRL_SLV 4:3
`define XT_THR_CODE 7:0
`define XT_THR_PRE 9:8
`define XT_LBL_DATA 9:0
`define XT_LBL_IDX 12:10
`define XT_CNT_STAGE 3:0
`define XT_COMMIT_GO 0

// Threshold presets and codes in 0.05 V steps
`define XT_PRE_CUSTOM 2'h0
`define XT_PRE_TTL 2'h1
`define XT_PRE_CMOS 2'h2
`define XT_PRE_ECL 2'h3
`define XT_THR_TTL 8'h1c
`define XT_THR_CMOS 8'h32
`define XT_THR_ECL 8'he6

// Reset values
`define XT_RST_THR 10'h11c
`define XT_RST_EDGE 8'h00
`define XT_RST_OWN 1'b1

`endif

// File: pkg/xt_pkg.sv
// Types and decode functions of the trace capture front end
package xt_pkg;
  typedef enum logic [1:0] {MODE_EMUL, MODE_STATE, MODE_TIMING} mode_t;
  typedef enum logic [1:0] {SLV_OFF, SLV_MIXED, SLV_DEMUX} slave_t;

  // Code 3 is illegal and falls back to emulation
  function automatic mode_t to_mode(input logic [1:0] c);
    unique case (c)
      2'h1: to_mode = MODE_STATE;
      2'h2: to_mode = MODE_TIMING;
      default: to_mode = MODE_EMUL;
    endcase
  endfunction

  function automatic slave_t to_slave(input logic [1:0] c);
    unique case (c)
      2'h1: to_slave = SLV_MIXED;
      2'h2: to_slave = SLV_DEMUX;
      default: to_slave = SLV_OFF;
    endcase
  endfunction
endpackage

// File: pkg/label_if.sv
// Port bundle between the capture core and its label memory
`timescale 1ns/100ps
interface label_if;
  logic we;
  logic [3:0] waddr;
  logic [9:0] wdata;
  logic [3:0] raddr;
  logic [9:0] rdata;
  modport user(output we, output waddr, output wdata, output raddr, input rdata);
  modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: verilog/label_ram.sv
// Two-bank label store with registered read data
`timescale 1ns/100ps
module label_ram #(
  parameter int DEPTH = 16 // Words, two banks
) (
  input wire logic clock, // System clock
  label_if.mem bus // Write and read port
);
  logic [9:0] mem_q [DEPTH];

  // Address is four bits wide
  if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
    $error("label_ram depth out of range");
  end

  // Storage needs no reset; the active count gates what is valid
  always_ff @(posedge clock) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end

  // Read data from a register
  always_ff @(posedge clock) begin
    bus.rdata <= mem_q[bus.raddr];
  end
endmodule

// File: verilog/ext_trace_capture.sv
// External trace channel capture with slave clock demultiplexing
`timescale 1ns/100ps
`include "xt_params.svh"
module ext_trace_capture
  import xt_pkg::*;
#(
  parameter int NLAB = 8 // Labels per set
) (
  input wire logic clock, // System clock, 50 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [15:0] ext_ch, // Probe channels
  input wire logic clk_j, // Probe clock, lower group
  input wire logic clk_k, // Probe clock, upper group
  input wire logic clk_l, // Emulator clock L
  input wire logic clk_m, // Emulator clock M
  input wire logic emu_clk, // Emulation clock
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, next cycle
  output logic [15:0] trace_data, // Captured sample
  output logic trace_valid, // Sample strobe
  output logic [15:0] qual_data, // Analyzer qualifier data
  output logic qual_valid, // Qualifier strobe
  output logic [15:0] indep_data, // Independent path data
  output logic indep_valid, // Independent path strobe
  output logic indep_timing, // Independent data is binary timing
  output logic [7:0] thr_lo_code, // Lower group reference code
  output logic [7:0] thr_hi_code // Upper group reference code
);
  logic [20:0] pin_s1, pin_s2, pin_s3;
  logic [15:0] din;
  logic master_evt, slave_evt, cap_evt;
  logic own_reg;
  logic [1:0] mode_stage_reg, slv_stage_reg;
  logic [9:0] thr_lo_stage_reg, thr_hi_stage_reg;
  logic [7:0] edge_stage_reg, edge_act_reg;
  logic [3:0] cnt_stage_reg, lbl_cnt_reg;
  logic [2:0] lbl_sel_reg;
  logic act_bank_reg;
  mode_t act_mode_reg;
  slave_t act_slv_reg, slv_eff;
  logic commit, apply;
  logic lat_full, lat_next_full;
  logic [7:0] lat_lo, lo_samp;
  logic [15:0] trace_next;
  label_if lab ();

  if (NLAB < 1 || NLAB > 8) begin : g_bad_nlab
    $error("NLAB must be 1 to 8");
  end

  // Threshold preset decode, signed 0.05 V steps
  function automatic logic [7:0] thr_eff(input logic [9:0] v);
    unique case (v[`XT_THR_PRE])
      `XT_PRE_TTL: thr_eff = `XT_THR_TTL;
      `XT_PRE_CMOS: thr_eff = `XT_THR_CMOS;
      `XT_PRE_ECL: thr_eff = `XT_THR_ECL;
      default: thr_eff = v[`XT_THR_CODE];
    endcase
  endfunction

  // Edge select: bit0 rising, bit1 falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    edge_hit = (sel[0] & cur & ~prv) | (sel[1] & ~cur & prv);
  endfunction

  // Two-stage synchronisers, third stage only for edges
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_s1 <= 21'h0;
      pin_s2 <= 21'h0;
      pin_s3 <= 21'h0;
    end else begin
      pin_s1 <= {emu_clk, clk_m, clk_l, clk_k, clk_j, ext_ch};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign din = pin_s2[15:0];
  assign master_evt = pin_s2[20] & ~pin_s3[20];

  // Any selected edge on any source is a slave event
  always_comb begin
    slave_evt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      slave_evt = slave_evt | edge_hit(edge_act_reg[2*i+:2], pin_s2[16+i], pin_s3[16+i]);
    end
  end

  assign commit = reg_wr && reg_addr == `XT_A_COMMIT && reg_wdata[`XT_COMMIT_GO];
  assign apply = commit & own_reg;

  // Staged settings; nothing here touches capture until commit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      own_reg <= `XT_RST_OWN;
      mode_stage_reg <= 2'h0;
      slv_stage_reg <= 2'h0;
      thr_lo_stage_reg <= `XT_RST_THR;
      thr_hi_stage_reg <= `XT_RST_THR;
      edge_stage_reg <= `XT_RST_EDGE;
      cnt_stage_reg <= 4'h0;
      lbl_sel_reg <= 3'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `XT_A_CTRL: begin
          own_reg <= reg_wdata[`XT_CTRL_OWN];
          mode_stage_reg <= reg_wdata[`XT_CTRL_MODE];
          slv_stage_reg <= reg_wdata[`XT_CTRL_SLV];
        end
        `XT_A_THR_LO: thr_lo_stage_reg <= reg_wdata[9:0];
        `XT_A_THR_HI: thr_hi_stage_reg <= reg_wdata[9:0];
        `XT_A_EDGE: edge_stage_reg <= reg_wdata[7:0];
        `XT_A_LBL_CNT: cnt_stage_reg <= reg_wdata[`XT_CNT_STAGE];
        `XT_A_LBL_SEL: lbl_sel_reg <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Commit applies the whole set in one edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      act_mode_reg <= MODE_EMUL;
      act_slv_reg <= SLV_OFF;
      thr_lo_code <= `XT_THR_TTL;
      thr_hi_code <= `XT_THR_TTL;
      edge_act_reg <= `XT_RST_EDGE;
    end else if (apply) begin
      act_mode_reg <= to_mode(mode_stage_reg);
      act_slv_reg <= to_slave(slv_stage_reg);
      thr_lo_code <= thr_eff(thr_lo_stage_reg);
      thr_hi_code <= thr_eff(thr_hi_stage_reg);
      edge_act_reg <= edge_stage_reg;
    end
  end

  // Bank swap drops the old label set at once
  always_ff @(posedge clock) begin
    if (!nrst) begin
      act_bank_reg <= 1'b0;
      lbl_cnt_reg <= 4'h0;
    end else if (apply) begin
      act_bank_reg <= ~act_bank_reg;
      lbl_cnt_reg <= (cnt_stage_reg > 4'(NLAB)) ? 4'(NLAB) : cnt_stage_reg;
    end
  end

  // Labels land in the inactive bank; out of range index ignored
  assign lab.we = reg_wr && reg_addr == `XT_A_LBL_WR && 32'(reg_wdata[`XT_LBL_IDX]) < NLAB;
  assign lab.waddr = {~act_bank_reg, reg_wdata[`XT_LBL_IDX]};
  assign lab.wdata = reg_wdata[`XT_LBL_DATA];
  assign lab.raddr = {act_bank_reg, lbl_sel_reg};

  label_ram #(.DEPTH(16)) u_labels (
    .clock(clock),
    .bus(lab)
  );

  // Slave clocking exists only in independent state mode
  assign slv_eff = (act_mode_reg == MODE_STATE) ? act_slv_reg : SLV_OFF;

  // First slave event per master interval wins; a coincident one opens the next
  assign lat_next_full = slave_evt && (!lat_full || master_evt);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lat_full <= 1'b0;
      lat_lo <= 8'h00;
    end else if (lat_next_full) begin
      lat_full <= 1'b1;
      lat_lo <= din[7:0];
    end else if (master_evt) begin
      lat_full <= 1'b0;
    end
  end

  assign lo_samp = lat_full ? lat_lo : din[7:0];

  // Trace word assembly per slave mode
  always_comb begin
    unique case (slv_eff)
      SLV_OFF: trace_next = din;
      SLV_MIXED: trace_next = {din[15:8], lo_samp};
      SLV_DEMUX: trace_next = {din[7:0], lo_samp};
    endcase
  end

  // Timing mode samples every clock, others on emulation clock
  assign cap_evt = (act_mode_reg == MODE_TIMING) ? 1'b1 : master_evt;

  // Common trace output
  always_ff @(posedge clock) begin
    if (!nrst) begin
      trace_valid <= 1'b0;
      trace_data <= 16'h0000;
    end else begin
      trace_valid <= cap_evt;
      if (cap_evt) begin
        trace_data <= trace_next;
      end
    end
  end

  // Analyzer qualifier path, emulation mode only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      qual_valid <= 1'b0;
      qual_data <= 16'h0000;
    end else begin
      qual_valid <= master_evt && act_mode_reg == MODE_EMUL;
      if (master_evt && act_mode_reg == MODE_EMUL) begin
        qual_data <= trace_next;
      end
    end
  end

  // Independent path for state commands and binary timing dump
  always_ff @(posedge clock) begin
    if (!nrst) begin
      indep_valid <= 1'b0;
      indep_data <= 16'h0000;
      indep_timing <= 1'b0;
    end else begin
      indep_valid <= cap_evt && act_mode_reg != MODE_EMUL;
      indep_timing <= act_mode_reg == MODE_TIMING;
      if (cap_evt && act_mode_reg != MODE_EMUL) begin
        indep_data <= trace_next;
      end
    end
  end

  // Read data stand one cycle only
  always_ff @(posedge clock) begin
    if (!nrst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      unique case (reg_addr)
        `XT_A_CTRL: reg_rdata <= {11'h0, slv_stage_reg, mode_stage_reg, own_reg};
        `XT_A_THR_LO: reg_rdata <= {6'h0, thr_lo_stage_reg};
        `XT_A_THR_HI: reg_rdata <= {6'h0, thr_hi_stage_reg};
        `XT_A_EDGE: reg_rdata <= {8'h0, edge_stage_reg};
        `XT_A_LBL_CNT: reg_rdata <= {8'h0, lbl_cnt_reg, cnt_stage_reg};
        `XT_A_STATUS: reg_rdata <= {10'h0, lat_full, act_bank_reg, slv_eff, act_mode_reg};
        `XT_A_TRACE: reg_rdata <= trace_data;
        `XT_A_LBL_SEL: reg_rdata <= {6'h0, lab.rdata};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Checks
  AST_RST_TTL: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> thr_lo_code == `XT_THR_TTL && thr_hi_code == `XT_THR_TTL)
    else $error("threshold not TTL after reset");
  AST_RST_EMUL: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> act_mode_reg == MODE_EMUL && !indep_valid)
    else $error("mode not emulation after reset");
  AST_QUAL_EMUL: assert property (@(posedge clock) disable iff (!nrst)
    qual_valid |-> $past(act_mode_reg) == MODE_EMUL && trace_valid && qual_data == trace_data)
    else $error("qualifier data outside emulation mode");
  AST_WITHHELD: assert property (@(posedge clock) disable iff (!nrst)
    act_mode_reg != MODE_EMUL |=> !qual_valid)
    else $error("channels leaked to analyzer");
  AST_TIMING_BIN: assert property (@(posedge clock) disable iff (!nrst)
    act_mode_reg == MODE_TIMING [*2] |-> indep_valid && indep_timing && indep_data == $past(din))
    else $error("timing data not delivered raw");
  AST_NO_OWN: assert property (@(posedge clock) disable iff (!nrst)
    commit && !own_reg |=> $stable(act_mode_reg) && $stable(thr_lo_code)
      && $stable(thr_hi_code) && $stable(act_bank_reg) && $stable(edge_act_reg))
    else $error("setup changed without ownership");
  AST_APPLY: assert property (@(posedge clock) disable iff (!nrst)
    apply |=> act_mode_reg == to_mode($past(mode_stage_reg))
      && thr_lo_code == thr_eff($past(thr_lo_stage_reg))
      && act_bank_reg != $past(act_bank_reg))
    else $error("commit did not apply all settings");
  AST_OFF_DIRECT: assert property (@(posedge clock) disable iff (!nrst)
    master_evt && slv_eff == SLV_OFF |=> trace_data == $past(din))
    else $error("direct capture mismatch");
  AST_FIRST_KEPT: assert property (@(posedge clock) disable iff (!nrst)
    lat_full && slave_evt && !master_evt |=> $stable(lat_lo) && lat_full)
    else $error("later slave sample overwrote first");
  AST_DEMUX: assert property (@(posedge clock) disable iff (!nrst)
    master_evt && slv_eff == SLV_DEMUX |=> trace_data[15:8] == $past(din[7:0])
      && trace_data[7:0] == $past(lo_samp))
    else $error("demux word mismatch");
  AST_SLAVE_EDGE: assert property (@(posedge clock) disable iff (!nrst)
    edge_act_reg[0] && pin_s2[16] && !pin_s3[16] |-> slave_evt)
    else $error("rising edge of probe clock missed");

  COV_MIXED: cover property (@(posedge clock) disable iff (!nrst)
    master_evt && lat_full && slv_eff == SLV_MIXED);
  COV_DEMUX: cover property (@(posedge clock) disable iff (!nrst)
    master_evt && slv_eff == SLV_DEMUX);
  COV_APPLY: cover property (@(posedge clock) disable iff (!nrst) apply ##[1:20] qual_valid);
  COV_TIMING: cover property (@(posedge clock) disable iff (!nrst)
    indep_valid && indep_timing);
endmodule

// File: verif/target_model.sv
// Target side model: probe channels and slave clock sources, framed on the emulation clock
`timescale 1ns/100ps
module target_model (
  input wire logic emu_clk, // Emulation clock, a frame starts at its rise
  output logic [15:0] ext_ch, // Probe channels
  output logic [3:0] slv_clk // Slave sources J, K, L, M
);
  // Slave sources stand still low outside frames
  initial begin
    ext_ch = 16'h0000;
    slv_clk = 4'h0;
  end

  // Word settles mid-period, lower byte changes after the first pulse
  task automatic frame(input logic [7:0] up, input logic [7:0] l1, input logic [7:0] l2,
                       input int n, input int src);
    @(posedge emu_clk);
    #85 ext_ch = {up, l1};
    #20 slv_clk[src] = (n > 0);
    #20 slv_clk[src] = 1'b0;
    #15 ext_ch[7:0] = l2;
    #5 slv_clk[src] = (n > 1);
    #20 slv_clk[src] = 1'b0; // Late fall lands in the next interval
  endtask

  // Static word for the timing path
  task automatic hold(input logic [15:0] w);
    ext_ch <= w; // Called on a clock edge; lands after the design has sampled
  endtask
endmodule

// File: verif/ext_trace_capture_tb_top.sv
// Self-checking bench of the external trace capture front end
`timescale 1ns/100ps
module ext_trace_capture_tb_top;
  logic clock, nrst, emu_clk, reg_wr, reg_rd, trace_valid, qual_valid, indep_valid, indep_timing;
  logic [3:0] reg_addr, slv_clk;
  logic [15:0] reg_wdata, ext_ch, reg_rdata, trace_data, qual_data, indep_data, w;
  logic [7:0] thr_lo_code, thr_hi_code, code, hc, last_lo, e;
  logic [1:0] cur_m, cur_s;
  logic [9:0] lab [6];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i, s, k;
  int cv [5] = '{140, 250, -130, -640, 635};
  logic [1:0] pv [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  int mc [3] = '{0, 1, 3};

  // System clock 50 MHz, emulation clock 160 ns with an unrelated phase
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    emu_clk = 1'b0;
    #33;
    forever #80 emu_clk = ~emu_clk;
  end

  ext_trace_capture #(.NLAB(6)) i_ext_trace_capture (
    .clock(clock), .nrst(nrst), .ext_ch(ext_ch), .clk_j(slv_clk[0]), .clk_k(slv_clk[1]),
    .clk_l(slv_clk[2]), .clk_m(slv_clk[3]), .emu_clk(emu_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trace_data(trace_data), .trace_valid(trace_valid), .qual_data(qual_data),
    .qual_valid(qual_valid), .indep_data(indep_data), .indep_valid(indep_valid),
    .indep_timing(indep_timing), .thr_lo_code(thr_lo_code), .thr_hi_code(thr_hi_code));

  target_model i_target_model (.emu_clk(emu_clk), .ext_ch(ext_ch), .slv_clk(slv_clk));

  task automatic print_verdict();
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // One-cycle strobes; a clock edge always separates two accesses
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] msk);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk($sformatf("register %h", a), exp, reg_rdata & msk);
  endtask

  // Expected capture word for one frame under the active setup
  function automatic logic [15:0] exp_word(input logic [1:0] es, input int n,
                                           input logic [7:0] u, input logic [7:0] a,
                                           input logic [7:0] b);
    logic [7:0] lower;
    lower = (n > 0 && es != 2'h0) ? a : b;
    if (cur_s == 2'h1) return {u, lower};
    if (cur_s == 2'h2) return {b, lower};
    return {u, b};
  endfunction

  // Stage mode, slave and edges, commit, then confirm the effective setup
  task automatic cfg(input logic [1:0] m, input logic [1:0] sv, input logic [7:0] ev);
    wr(4'h0, {11'h0, sv, m, 1'b1});
    wr(4'h3, {8'h0, ev});
    wr(4'h6, 16'h0001);
    cur_m = (m == 2'h3) ? 2'h0 : m;
    cur_s = (cur_m == 2'h1 && sv != 2'h3) ? sv : 2'h0;
    rchk(4'h7, {12'h0, cur_s, cur_m}, 16'h000f);
  endtask

  task automatic cap(input int n, input int src);
    logic [7:0] u, a, b;
    logic [15:0] x, rexp;
    u = 8'($urandom);
    a = 8'($urandom);
    b = 8'($urandom);
    x = exp_word(e[2*src +: 2], n, u, a, b);
    rexp = {12'h0, 1'b1, cur_m == 2'h0, cur_m == 2'h1, 1'b0};
    i_target_model.frame(u, a, b, n, src);
    @(posedge clock);
    for (k = 0; k < 12 && trace_valid !== 1'b1; k++) @(posedge clock);
    chk("trace_data", x, trace_data);
    chk("routing", rexp, {12'h0, trace_valid, qual_valid, indep_valid, indep_timing});
    chk("path_data", x, (cur_m == 2'h0) ? qual_data : indep_data);
  endtask

  // Fill every label of the inactive bank, commit, read each one back
  task automatic labels();
    for (i = 0; i < 6; i++) begin
      lab[i] = 10'($urandom);
      wr(4'h4, {3'h0, 3'(i), lab[i]});
    end
    wr(4'h5, 16'h000f);
    wr(4'h6, 16'h0001);
    rchk(4'h5, 16'h006f, 16'hffff);
    for (i = 0; i < 6; i++) begin
      wr(4'h9, 16'(i));
      repeat (2) @(posedge clock);
      rchk(4'h9, {6'h0, lab[i]}, 16'hffff);
    end
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(32'h43a4));
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    // Reset values, unmapped index ignored
    rchk(4'h0, 16'h0001, 16'hffff);
    rchk(4'h1, 16'h011c, 16'hffff);
    rchk(4'h2, 16'h011c, 16'hffff);
    rchk(4'h3, 16'h0000, 16'hffff);
    rchk(4'h7, 16'h0000, 16'hffff);
    wr(4'hc, 16'hffff);
    rchk(4'hc, 16'h0000, 16'hffff);
    chk("thr_lo_code", 16'h001c, {8'h0, thr_lo_code});
    // Presets and range ends in 10 mV units, 0.05 V per code step
    last_lo = 8'h1c;
    for (i = 0; i < 5; i++) begin
      code = 8'(cv[i] / 5);
      hc = 8'($urandom);
      wr(4'h1, {6'h0, pv[i], (pv[i] == 2'h0) ? code : 8'($urandom)});
      wr(4'h2, {8'h0, hc});
      @(posedge clock);
      chk("thr_lo_held", {8'h0, last_lo}, {8'h0, thr_lo_code});
      wr(4'h6, 16'h0001);
      @(posedge clock);
      chk("thr_lo_code", {8'h0, code}, {8'h0, thr_lo_code});
      chk("thr_hi_code", {8'h0, hc}, {8'h0, thr_hi_code});
      last_lo = code;
    end
    // Without ownership a commit changes nothing, bank stays at 1
    wr(4'h0, 16'h000a);
    wr(4'h1, 16'h0005);
    wr(4'h6, 16'h0001);
    @(posedge clock);
    chk("thr_lo_owned", {8'h0, last_lo}, {8'h0, thr_lo_code});
    rchk(4'h7, 16'h0010, 16'hffff);
    wr(4'h0, 16'h0001);
    labels();
    labels();
    // Timing path delivers every clock
    cfg(2'h2, 2'h1, 8'hff);
    w = 16'($urandom);
    i_target_model.hold(w);
    repeat (6) @(posedge clock);
    chk("timing_flags", 16'h000e, {12'h0, trace_valid, indep_valid, indep_timing, qual_valid});
    chk("timing_data", w, indep_data);
    // Corner: two pulses under rising, then falling edge select, first kept; expectation reads the edge set from e
    e = 8'h55;
    cfg(2'h1, 2'h1, e);
    cap(2, 0);
    e = 8'haa;
    cfg(2'h1, 2'h2, e);
    cap(2, 3);
    // Mode codes 0, 1 and 3 (no timing) with every slave code, random edges and pulses
    for (i = 0; i < 3; i++) begin
      for (s = 0; s < 4; s++) begin
        e = 8'($urandom);
        cfg(2'(mc[i]), 2'(s), e);
        repeat (3) cap($urandom_range(0, 2), $urandom_range(0, 3));
      end
    end
    print_verdict();
  end
endmodule
